// ---- core/dss_device.sv ----
// Converter side: config registers, sync selection, FIFO pointers, divider, gating.
// Assumes link inputs synchronous to clk_sys_i, which stands for the conversion clock.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dss_device #(
    parameter int unsigned DEPTH     = 8,
    parameter int unsigned FIFO_OFS  = 4,
    parameter int unsigned DIV_RATIO = 2,
    parameter int unsigned PLL_N     = 16
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    dss_link_if.dev                     lnk,
    input  wire logic                   conv_clock_lost_i,
    output logic [dss_pkg::DW-1:0]      dac_data_o,
    output logic                        dac_valid_o,
    output logic                        fmt_phase_o,
    output logic                        fuse_sleep_o,
    output logic                        tx_active_o
);
    import dss_pkg::*;

    localparam int unsigned PW  = $clog2(DEPTH);
    localparam int unsigned DVW = $clog2(DIV_RATIO);
    localparam int unsigned PNW = $clog2(PLL_N);
    localparam int unsigned LCW = $clog2(DCLK_LOSS_CYC + 1);

    // Refuse parameters the pointers and dividers cannot serve
    if (DEPTH < 4 || (1 << PW) != DEPTH || FIFO_OFS >= DEPTH || DIV_RATIO < 2 || PLL_N < 2)
    begin
        $error("dss_device: unsupported parameters");
    end

    typedef struct packed {
        logic [NREG-1:0][DW-1:0]  regs;
        logic [DW-1:0]            rdata;
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [PW-1:0]            wptr;
        logic [PW-1:0]            rptr;
        logic [DVW-1:0]           div_cnt;
        logic [PNW-1:0]           pll_cnt;
        logic [LCW-1:0]           loss_cnt;
        logic [DW-1:0]            dout;
        logic                     frame_q;
        logic                     sync_q;
        logic                     ostr_q;
        logic                     dclk_q;
        logic                     armed;
        logic                     fmt_phase;
        logic                     alarm;
        logic                     txa;
        logic                     valid;
        logic                     fuse;
    } dss_dev_state_t;

    dss_dev_state_t s_r;
    dss_dev_state_t s_nxt;

    logic [3:0]    idx;
    logic          ev_sync;
    logic          ev_frame;
    logic          ev_ostr;
    logic          ev_sif;
    logic          dclk_up;
    logic          pll_wrap;
    logic          div_wrap;
    logic [15:0]   evv;
    logic [DW-1:0] main_r;
    logic [DW-1:0] pll_r;
    logic [DW-1:0] ptr_r;
    logic [DW-1:0] blk_r;

    assign idx      = dss_idx(lnk.cfg_addr);
    assign main_r   = s_r.regs[dss_idx(ADR_MAIN)];
    assign pll_r    = s_r.regs[dss_idx(ADR_PLL)];
    assign blk_r    = s_r.regs[dss_idx(ADR_BLOCK_SYNC)];
    assign ptr_r    = s_r.regs[dss_idx(ADR_PTR_SYNC)];
    assign ev_sync  = lnk.sync_marker & ~s_r.sync_q;
    assign ev_frame = lnk.frame_marker & ~s_r.frame_q;
    assign dclk_up  = lnk.data_clock_in & ~s_r.dclk_q;
    assign pll_wrap = s_r.pll_cnt == PNW'(PLL_N - 1);
    assign div_wrap = s_r.div_cnt == DVW'(DIV_RATIO - 1);
    // Strobe from PLL divider in PLL mode, else external pin
    assign ev_ostr  = pll_r[PLL_ENA_BIT] ? pll_wrap : (lnk.output_strobe & ~s_r.ostr_q);
    assign ev_sif   = lnk.cfg_wr && lnk.cfg_addr == ADR_BLOCK_SYNC && lnk.cfg_wdata[SIF_SYNC_BIT];
    // code zero maps to no event
    assign evv      = {11'h000, ev_ostr, ev_sif, ev_frame, ev_sync, 1'b0};

    always_comb
    begin
        logic          wsync;
        logic          rsync;
        logic          fsync;
        logic          dsync;
        logic          psync;
        logic [DW-1:0] alm;
        logic [DW-1:0] shut;
        wsync = 1'b0;
        rsync = 1'b0;
        fsync = 1'b0;
        dsync = 1'b0;
        psync = 1'b0;
        alm   = '0;
        shut  = '0;
        s_nxt = s_r;
        wsync = evv[ptr_r[PTR_IN_LSB +: 4]];
        rsync = evv[ptr_r[PTR_OUT_LSB +: 4]];
        case (blk_r[FMT_SEL_LSB +: 2])
            FMT_FRAME: fsync = ev_frame;
            FMT_SYNC:  fsync = ev_sync;
            default:   fsync = 1'b0;
        endcase
        dsync = main_r[MAIN_DIVSYNC_BIT] & (ptr_r[DIV_SEL_BIT] ? ev_frame : ev_ostr);
        psync = pll_r[PLL_ENA_BIT] & pll_r[PLL_NSYNC_BIT] & ev_sync;

        s_nxt.frame_q = lnk.frame_marker;
        s_nxt.sync_q  = lnk.sync_marker;
        s_nxt.ostr_q  = lnk.output_strobe;
        s_nxt.dclk_q  = lnk.data_clock_in;

        s_nxt.pll_cnt = (psync | pll_wrap) ? '0 : s_r.pll_cnt + 1'b1;
        s_nxt.div_cnt = (dsync | div_wrap) ? '0 : s_r.div_cnt + 1'b1;

        if (dclk_up)
        begin
            s_nxt.mem[s_r.wptr] = lnk.sample;
            s_nxt.wptr          = s_r.wptr + 1'b1;
            s_nxt.fmt_phase     = ~s_r.fmt_phase;
        end
        if (wsync)
            s_nxt.wptr = '0;
        if (fsync)
            s_nxt.fmt_phase = 1'b0;

        s_nxt.valid = 1'b0;
        if (div_wrap)
        begin
            s_nxt.dout  = s_r.txa ? s_r.mem[s_r.rptr] : '0;
            s_nxt.valid = s_r.txa;
            s_nxt.rptr  = s_r.rptr + 1'b1;
        end
        if (rsync)
        begin
            s_nxt.rptr  = PW'(FIFO_OFS);
            s_nxt.armed = 1'b1;
        end

        if (dclk_up)
            s_nxt.loss_cnt = '0;
        else if (s_r.loss_cnt != LCW'(DCLK_LOSS_CYC))
            s_nxt.loss_cnt = s_r.loss_cnt + 1'b1;

        // Register writes
        if (lnk.cfg_wr && idx != IDX_NONE && idx != IDX_ALARM)
            s_nxt.regs[idx] = lnk.cfg_wdata;

        // zero write clears, new events win
        alm = s_r.regs[IDX_ALARM];
        if (lnk.cfg_wr && idx == IDX_ALARM)
            alm = lnk.cfg_wdata;
        alm[ALM_COLL]    = alm[ALM_COLL] | (s_r.armed && s_r.wptr == s_r.rptr);
        alm[ALM_DATACLK] = alm[ALM_DATACLK] | (s_r.loss_cnt == LCW'(DCLK_LOSS_CYC));
        alm[ALM_DACCLK]  = alm[ALM_DACCLK] | conv_clock_lost_i;
        s_nxt.regs[IDX_ALARM] = alm;

        s_nxt.alarm = |(alm & ~s_r.regs[dss_idx(ADR_ALARM_MASK)]);
        shut = s_r.regs[dss_idx(ADR_SHUTOFF)];
        s_nxt.txa = (lnk.tx_gate | s_r.regs[dss_idx(ADR_CURRENT)][TXEN_BIT])
                    & ~(shut[SHUT_COLL] & alm[ALM_COLL])
                    & ~(shut[SHUT_DATACLK] & alm[ALM_DATACLK])
                    & ~(shut[SHUT_DACCLK] & alm[ALM_DACCLK]);
        s_nxt.fuse = s_r.regs[dss_idx(ADR_FUSE)][FUSE_SLEEP_BIT];

        s_nxt.rdata = (lnk.cfg_rd && idx != IDX_NONE) ? s_r.regs[idx] : '0;

        if (!lnk.active_low_reset_pin_n)
        begin
            s_nxt      = '0;
            s_nxt.regs = {NREG{REG_RST}};
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign lnk.cfg_rdata = s_r.rdata;
    assign lnk.alarm     = s_r.alarm;
    assign dac_data_o    = s_r.dout;
    assign dac_valid_o   = s_r.valid;
    assign fmt_phase_o   = s_r.fmt_phase;
    assign fuse_sleep_o  = s_r.fuse;
    assign tx_active_o   = s_r.txa;
endmodule
`default_nettype wire

// ---- common/dss_pkg.sv ----
// Constants for the converter start-up and sync loader.
// Assumes one system clock of 4 ns shared by both ends.
package dss_pkg;
    localparam int unsigned DW = 16;
    localparam int unsigned AW = 6;
    // Device register addresses
    localparam logic [5:0] ADR_MAIN       = 6'h00;
    localparam logic [5:0] ADR_PARITY_FMT = 6'h01;
    localparam logic [5:0] ADR_SHUTOFF    = 6'h02;
    localparam logic [5:0] ADR_CURRENT    = 6'h03;
    localparam logic [5:0] ADR_ALARM      = 6'h05;
    localparam logic [5:0] ADR_ALARM_MASK = 6'h07;
    localparam logic [5:0] ADR_OFFSET_I   = 6'h08;
    localparam logic [5:0] ADR_CORR_PHASE = 6'h10;
    localparam logic [5:0] ADR_PLL        = 6'h18;
    localparam logic [5:0] ADR_FUSE       = 6'h1B;
    localparam logic [5:0] ADR_BLOCK_SYNC = 6'h1F;
    localparam logic [5:0] ADR_PTR_SYNC   = 6'h20;
    localparam int unsigned NREG = 12;
    localparam logic [3:0] IDX_NONE  = 4'hF;
    localparam logic [3:0] IDX_ALARM = 4'h4;
    localparam logic [DW-1:0] REG_RST = 16'h0000;
    // Field positions
    localparam int unsigned MAIN_DIVSYNC_BIT = 2;
    localparam int unsigned PLL_ENA_BIT      = 10;
    localparam int unsigned PLL_NSYNC_BIT    = 11;
    localparam int unsigned FUSE_SLEEP_BIT   = 11;
    localparam int unsigned FMT_SEL_LSB      = 2;
    localparam int unsigned SIF_SYNC_BIT     = 1;
    localparam int unsigned PTR_IN_LSB       = 12;
    localparam int unsigned PTR_OUT_LSB      = 8;
    localparam int unsigned DIV_SEL_BIT      = 0;
    localparam int unsigned TXEN_BIT         = 0;
    localparam int unsigned SHUT_DACCLK      = 15;
    localparam int unsigned SHUT_DATACLK     = 14;
    localparam int unsigned SHUT_COLL        = 13;
    localparam int unsigned ALM_DATACLK      = 8;
    localparam int unsigned ALM_DACCLK       = 9;
    localparam int unsigned ALM_COLL         = 10;
    // Sync source codes
    localparam logic [3:0] SRC_SYNC  = 4'h1;
    localparam logic [3:0] SRC_FRAME = 4'h2;
    localparam logic [3:0] SRC_SIF   = 4'h3;
    localparam logic [3:0] SRC_OSTR  = 4'h4;
    localparam logic [1:0] FMT_FRAME = 2'h0;
    localparam logic [1:0] FMT_SYNC  = 2'h1;
    // Timing
    localparam int unsigned CLK_PS        = 4000;
    localparam int unsigned RST_PULSE_NS  = 25;
    localparam int unsigned RST_CYC       = (RST_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned DCLK_LOSS_NS  = 100;
    localparam int unsigned DCLK_LOSS_CYC = (DCLK_LOSS_NS * 1000) / CLK_PS;
    localparam int unsigned MARK_NS       = 16;
    localparam int unsigned MARK_CYC      = (MARK_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned ALIGN_CYC     = 64;
    // Host start-up table
    localparam int unsigned TBL_N       = 15;
    localparam int unsigned CFG_END     = 10;
    localparam int unsigned RESYNC_IDX  = 6;
    localparam logic [TBL_N-1:0][5:0] TBL_ADR = {
        ADR_PLL, ADR_PTR_SYNC, ADR_BLOCK_SYNC, ADR_MAIN, ADR_BLOCK_SYNC,
        ADR_PTR_SYNC, ADR_BLOCK_SYNC, ADR_PLL, ADR_MAIN, ADR_FUSE,
        ADR_CORR_PHASE, ADR_ALARM_MASK, ADR_CURRENT, ADR_SHUTOFF, ADR_PARITY_FMT};
    localparam logic [TBL_N-1:0][DW-1:0] TBL_VAL = {
        16'h2467, 16'h0000, 16'h4148, 16'hA19A, 16'h4142,
        16'h2400, 16'h4140, 16'h2C67, 16'hA19E, 16'h0800,
        16'h3000, 16'hD8FF, 16'hA000, 16'hF052, 16'h040E};
    // Host own registers
    localparam logic [1:0] HADR_CTRL   = 2'h0;
    localparam logic [1:0] HADR_STATUS = 2'h1;
    localparam int unsigned CTRL_START  = 0;
    localparam int unsigned CTRL_RESYNC = 1;

    function automatic logic [3:0] dss_idx(input logic [5:0] a);
        case (a)
            ADR_MAIN:       dss_idx = 4'h0;
            ADR_PARITY_FMT: dss_idx = 4'h1;
            ADR_SHUTOFF:    dss_idx = 4'h2;
            ADR_CURRENT:    dss_idx = 4'h3;
            ADR_ALARM:      dss_idx = IDX_ALARM;
            ADR_ALARM_MASK: dss_idx = 4'h5;
            ADR_OFFSET_I:   dss_idx = 4'h6;
            ADR_CORR_PHASE: dss_idx = 4'h7;
            ADR_PLL:        dss_idx = 4'h8;
            ADR_FUSE:       dss_idx = 4'h9;
            ADR_BLOCK_SYNC: dss_idx = 4'hA;
            ADR_PTR_SYNC:   dss_idx = 4'hB;
            default:        dss_idx = IDX_NONE;
        endcase
    endfunction
endpackage

// ---- common/dss_link_if.sv ----
// Link between host sequencer/data source and converter device.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface dss_link_if;
    logic                     active_low_reset_pin_n;
    logic [dss_pkg::AW-1:0]   cfg_addr;
    logic [dss_pkg::DW-1:0]   cfg_wdata;
    logic                     cfg_wr;
    logic                     cfg_rd;
    logic [dss_pkg::DW-1:0]   cfg_rdata;
    logic [dss_pkg::DW-1:0]   sample;
    logic                     parity_in;
    logic                     data_clock_in;
    logic                     frame_marker;
    logic                     sync_marker;
    logic                     output_strobe;
    logic                     tx_gate;
    logic                     alarm;
    modport dev (input active_low_reset_pin_n, cfg_addr, cfg_wdata, cfg_wr, cfg_rd, sample, parity_in,
                 data_clock_in, frame_marker, sync_marker, output_strobe, tx_gate,
                 output cfg_rdata, alarm);
    modport host (output active_low_reset_pin_n, cfg_addr, cfg_wdata, cfg_wr, cfg_rd, sample, parity_in,
                  data_clock_in, frame_marker, sync_marker, output_strobe, tx_gate,
                  input cfg_rdata, alarm);
endinterface
`default_nettype wire

// ---- core/dss_host.sv ----
// Host end: reset pulse, start-up table, alignment markers, alarm check, transmit gate.
// Assumes a software port with read data one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module dss_host (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    dss_link_if.host                    lnk,
    input  wire logic [1:0]             reg_addr_i,
    input  wire logic [dss_pkg::DW-1:0] reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic [dss_pkg::DW-1:0]      reg_rdata_o,
    input  wire logic [dss_pkg::DW-1:0] sample_i
);
    import dss_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_RST, H_CFG, H_ALIGN, H_CLR, H_RD, H_CHK, H_RUN} dss_hstate_t;

    typedef struct packed {
        dss_hstate_t   st;
        logic [3:0]    idx;
        logic [7:0]    cnt;
        logic          rst_n;
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          dclk;
        logic [DW-1:0] sample;
        logic          par;
        logic          mark;
        logic          tx;
        logic          faults;
        logic [DW-1:0] rdata;
    } dss_host_state_t;

    dss_host_state_t s_r;
    dss_host_state_t s_nxt;

    always_comb
    begin
        logic ctl_wr;
        ctl_wr      = reg_wr_i && reg_addr_i == HADR_CTRL;
        s_nxt       = s_r;
        s_nxt.wr    = 1'b0;
        s_nxt.rd    = 1'b0;
        s_nxt.rdata = '0;
        if (reg_rd_i && reg_addr_i == HADR_STATUS)
            s_nxt.rdata = {12'h000, s_r.faults, lnk.alarm, s_r.tx, s_r.st != H_IDLE && s_r.st != H_RUN};
        // data clock and bus run with the link
        if (s_r.st != H_IDLE && s_r.st != H_RST)
        begin
            s_nxt.dclk = ~s_r.dclk;
            if (s_r.dclk)
            begin
                s_nxt.sample = sample_i;
                s_nxt.par    = ^sample_i;
            end
        end
        case (s_r.st)
            H_IDLE:
            begin
                if (ctl_wr && reg_wdata_i[CTRL_START])
                begin
                    s_nxt.st    = H_RST;
                    s_nxt.cnt   = '0;
                    s_nxt.rst_n = 1'b0;
                end
            end
            // reset pulse of the least width
            H_RST:
            begin
                s_nxt.cnt = s_r.cnt + 1'b1;
                if (s_r.cnt == 8'(RST_CYC - 1))
                begin
                    s_nxt.rst_n = 1'b1;
                    s_nxt.idx   = '0;
                    s_nxt.st    = H_CFG;
                end
            end
            H_CFG:
            begin
                s_nxt.wr    = 1'b1;
                s_nxt.addr  = TBL_ADR[s_r.idx];
                s_nxt.wdata = TBL_VAL[s_r.idx];
                s_nxt.idx   = s_r.idx + 1'b1;
                s_nxt.cnt   = '0;
                if (s_r.idx == 4'(CFG_END - 1))
                    s_nxt.st = H_ALIGN;
                else if (s_r.idx == 4'(TBL_N - 1))
                    s_nxt.st = H_RUN;
            end
            H_ALIGN:
            begin
                s_nxt.cnt  = s_r.cnt + 1'b1;
                s_nxt.mark = s_r.cnt < 8'(MARK_CYC);
                if (s_r.cnt == 8'(ALIGN_CYC - 1))
                    s_nxt.st = H_CLR;
            end
            H_CLR:
            begin
                s_nxt.wr    = 1'b1;
                s_nxt.addr  = ADR_ALARM;
                s_nxt.wdata = '0;
                s_nxt.st    = H_RD;
            end
            H_RD:
            begin
                s_nxt.rd   = 1'b1;
                s_nxt.addr = ADR_ALARM;
                s_nxt.cnt  = '0;
                s_nxt.st   = H_CHK;
            end
            H_CHK:
            begin
                s_nxt.cnt = 8'h01;
                if (s_r.cnt != 8'h00)
                    s_nxt.st = (lnk.cfg_rdata != '0) ? H_CLR : H_CFG;
            end
            // gate on, drop and resync on alarm
            H_RUN:
            begin
                s_nxt.tx = 1'b1;
                if (lnk.alarm || (ctl_wr && reg_wdata_i[CTRL_RESYNC]))
                begin
                    s_nxt.tx     = 1'b0;
                    s_nxt.faults = s_r.faults | lnk.alarm;
                    s_nxt.idx    = 4'(RESYNC_IDX);
                    s_nxt.st     = H_CFG;
                end
            end
            default:
                s_nxt.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_r       <= '0;
            s_r.st    <= H_IDLE;
            s_r.rst_n <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign lnk.active_low_reset_pin_n = s_r.rst_n;
    assign lnk.cfg_addr               = s_r.addr;
    assign lnk.cfg_wdata              = s_r.wdata;
    assign lnk.cfg_wr                 = s_r.wr;
    assign lnk.cfg_rd                 = s_r.rd;
    assign lnk.sample                 = s_r.sample;
    assign lnk.parity_in              = s_r.par;
    assign lnk.data_clock_in          = s_r.dclk;
    assign lnk.frame_marker           = s_r.mark;
    assign lnk.sync_marker            = s_r.mark;
    assign lnk.output_strobe          = 1'b0;
    assign lnk.tx_gate                = s_r.tx;
    assign reg_rdata_o                = s_r.rdata;
endmodule
`default_nettype wire

// ---- verif/dss_link_props.sv ----
// Checker on the link signals between host and device.
// Assumes one clock domain; instantiated next to the link.
`timescale 1ns/1ps
`default_nettype none
module dss_link_props (
    input wire logic                   clk_sys_i,
    input wire logic                   rst_i,
    input wire logic                   active_low_reset_pin_n,
    input wire logic [dss_pkg::AW-1:0] cfg_addr,
    input wire logic [dss_pkg::DW-1:0] cfg_wdata,
    input wire logic                   cfg_wr,
    input wire logic                   cfg_rd,
    input wire logic [dss_pkg::DW-1:0] cfg_rdata,
    input wire logic [dss_pkg::DW-1:0] sample,
    input wire logic                   parity_in,
    input wire logic                   frame_marker,
    input wire logic                   sync_marker,
    input wire logic                   tx_gate,
    input wire logic                   alarm
);
    import dss_pkg::*;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    a_reset_width:
        assert property ($fell(active_low_reset_pin_n) |-> !active_low_reset_pin_n [*7])
        else $error("reset pin pulse too short");
    a_no_cfg_reset:
        assert property (!active_low_reset_pin_n |-> !cfg_wr && !cfg_rd)
        else $error("config access while reset pin low");
    a_rdata_idle:
        assert property (!$past(cfg_rd) |-> cfg_rdata == '0)
        else $error("read data outside its slot");
    a_strobe_excl:
        assert property (!(cfg_wr && cfg_rd))
        else $error("write and read strobe together");
    a_fmt_bit8:
        assert property (cfg_wr && cfg_addr == ADR_PARITY_FMT |-> !cfg_wdata[8])
        else $error("format bit 8 written high");
    a_phase_bits:
        assert property (cfg_wr && cfg_addr == ADR_CORR_PHASE |-> cfg_wdata[13:12] == 2'b11)
        else $error("phase bits 13:12 not 11");
    a_sync_pulse:
        assert property ($rose(sync_marker) |-> sync_marker [*4] ##1 !sync_marker)
        else $error("sync marker pulse width wrong");
    a_frame_pulse:
        assert property ($rose(frame_marker) |-> frame_marker [*4] ##1 !frame_marker)
        else $error("frame marker pulse width wrong");
    a_gate_in_reset:
        assert property (!active_low_reset_pin_n |-> !tx_gate)
        else $error("gate high during device reset");
    a_gate_drop:
        assert property (tx_gate && alarm |=> !tx_gate)
        else $error("gate kept high on alarm");
    a_parity_even:
        assert property (parity_in == ^sample)
        else $error("parity does not match sample");

    c_run: cover property ($rose(tx_gate));
    c_reset: cover property ($fell(active_low_reset_pin_n));
    c_fault: cover property (tx_gate && alarm);
endmodule
`default_nettype wire

// ---- verif/tb_dac_startup_sync_config.sv ----
// Testbench: host and device joined over the link.
// Assumes design files compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_dac_startup_sync_config;
    import dss_pkg::*;
    logic        clk_sys_i;
    logic        rst_i;
    logic [1:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [15:0] sample_i;
    logic        conv_lost;
    logic [15:0] dac_data;
    logic        dac_valid;
    logic        fuse_sleep;
    logic        fmt_phase;
    logic        p;
    logic        tx_active;
    logic [15:0] st;
    int          errors;
    int          samples_checked;
    int          n;

    dss_link_if u_dss_link_if ();
    dss_device u_dss_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .lnk(u_dss_link_if.dev),
        .conv_clock_lost_i(conv_lost), .dac_data_o(dac_data), .dac_valid_o(dac_valid),
        .fmt_phase_o(fmt_phase), .fuse_sleep_o(fuse_sleep), .tx_active_o(tx_active));
    dss_host u_dss_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .lnk(u_dss_link_if.host),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .sample_i(sample_i));
    dss_link_props u_dss_link_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .active_low_reset_pin_n(u_dss_link_if.active_low_reset_pin_n),
        .cfg_addr(u_dss_link_if.cfg_addr), .cfg_wdata(u_dss_link_if.cfg_wdata),
        .cfg_wr(u_dss_link_if.cfg_wr), .cfg_rd(u_dss_link_if.cfg_rd),
        .cfg_rdata(u_dss_link_if.cfg_rdata), .sample(u_dss_link_if.sample),
        .parity_in(u_dss_link_if.parity_in), .frame_marker(u_dss_link_if.frame_marker),
        .sync_marker(u_dss_link_if.sync_marker), .tx_gate(u_dss_link_if.tx_gate),
        .alarm(u_dss_link_if.alarm));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_gate(input logic v, input int lim);
        n = 0;
        while (u_dss_link_if.tx_gate !== v && n < lim)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        samples_checked++;
        if (u_dss_link_if.tx_gate !== v)
        begin
            errors++;
            $display("[ERR] %0t transmit gate wait timed out", $time);
            test_done();
        end
    endtask

    initial
    begin
        rst_i = 1'b1;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sample_i = 16'hA5C3;
        conv_lost = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wr(HADR_CTRL, 16'h0002);
        rd(HADR_STATUS, st);
        chk(st, 16'h0000);
        $display("idle refusal test done");
        wr(HADR_CTRL, 16'h0001);
        wait_gate(1'b1, 2000);
        chk(16'(fuse_sleep), 16'h0001);
        @(posedge clk_sys_i);
        #1;
        chk(16'(tx_active), 16'h0001);
        rd(HADR_STATUS, st);
        chk(st, 16'h0002);
        n = 0;
        repeat (20)
        begin
            @(posedge clk_sys_i);
            #1;
            if (dac_valid === 1'b1)
            begin
                n++;
                chk(dac_data, 16'hA5C3);
            end
        end
        chk(16'(n), 16'h000A);
        p = fmt_phase;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(16'(fmt_phase ^ p), 16'h0001);
        $display("start-up test done");
        @(posedge clk_sys_i);
        conv_lost <= 1'b1;
        wait_gate(1'b0, 10);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(16'(tx_active), 16'h0000);
        chk(dac_data, 16'h0000);
        @(posedge clk_sys_i);
        conv_lost <= 1'b0;
        wait_gate(1'b1, 2000);
        chk(16'(u_dss_link_if.alarm), 16'h0000);
        rd(HADR_STATUS, st);
        chk(st, 16'h000A);
        $display("clock loss test done");
        wr(HADR_CTRL, 16'h0002);
        wait_gate(1'b0, 4);
        wait_gate(1'b1, 2000);
        $display("software resync test done");
        wr(HADR_CTRL, 16'h0001);
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk(16'(u_dss_link_if.active_low_reset_pin_n), 16'h0001);
        chk(16'(u_dss_link_if.tx_gate), 16'h0001);
        $display("run refusal test done");
        test_done();
    end
endmodule
`default_nettype wire
